// ---- regbank_pkg.sv ----
package regbank_pkg;

	// ------------------------------------------------------------
	// Register indexes and byte address width
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_MODE_CTRL   = 8'h11;
	localparam logic [7:0] IDX_SPECIAL     = 8'h12;
	localparam logic [7:0] IDX_SYMERR      = 8'h1A;
	localparam logic [7:0] IDX_XOVER       = 8'h1B;
	localparam logic [7:0] IDX_SOFT_CTRL   = 8'h40;
	localparam logic [7:0] IDX_LINE_STATUS = 8'h41;
	localparam int         ADDR_W          = 10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_EDPD        = 13;
	localparam int BIT_REMOTE_LOOP = 9;
	localparam int BIT_ALT_IRQ     = 6;
	localparam int BIT_ENERGY      = 1;
	localparam int BIT_SPEC_RSVD1  = 14;
	localparam int MODE_LSB        = 5;
	localparam int MODE_W          = 3;
	localparam int ADDR_FLD_W      = 5;
	localparam int BIT_XOVER_DIS   = 15;
	localparam int BIT_PAIR_SEL    = 13;
	localparam int BIT_RX_POL      = 4;
	localparam int BIT_SOFT_RESET  = 0;
	localparam int BIT_SPEED_100   = 0;
	localparam int BIT_ISOLATE     = 1;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [15:0] SYMERR_RESET  = 16'h0000;
	localparam logic [15:0] SYMERR_ONE    = 16'h0001;
	localparam int          ENERGY_TIMEOUT_MS = 256;
	localparam longint      CLK_HZ        = 100000000;
	localparam longint      ENERGY_TIMEOUT_CYC = (CLK_HZ / 1000) * ENERGY_TIMEOUT_MS;

	// Receive-side events from the line logic
	typedef struct packed {
		logic energy_seen;  // Valid energy seen this cycle
		logic sym_invalid;  // Invalid code symbol received
		logic pkt_start;    // Start of a received packet
		logic pol_reversed; // 10BASE-T polarity detector result
	} line_events_t;

	// Control outputs towards the datapath
	typedef struct packed {
		logic                  energy_detect_powerdown_en;
		logic                  remote_loop_en;
		logic                  alternate_irq_select;
		logic                  auto_crossover_disable;
		logic                  manual_pair_select;
		logic [MODE_W-1:0]     mode;
		logic [ADDR_FLD_W-1:0] mgmt_address;
	} phy_ctrl_t;

endpackage

// ---- symbol_err_counter.sv ----
`timescale 1ns/1ns
`default_nettype none

// Counts invalid-symbol events in 100BASE-TX only, once per packet, wrapping at full scale
module symbol_err_counter #(
	parameter int WIDTH = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             speed_100,
	input  wire logic             sym_invalid,
	input  wire logic             pkt_start,
	output logic      [WIDTH-1:0] count
);

	logic counted_reg;

	// ------------------------------------------------------------
	// Per-packet gate
	// ------------------------------------------------------------
	// Once an error is counted, further errors wait for the next packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counted_reg <= 1'b0;
		end else if (speed_100 && sym_invalid) begin
			counted_reg <= 1'b1; // [RULE_12]
		end else if (pkt_start) begin
			counted_reg <= 1'b0;
		end
	end

	// Idle errors count too; natural overflow gives the wrap to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= WIDTH'(regbank_pkg::SYMERR_RESET); // [RULE_14]
		end else if (speed_100 && sym_invalid && (!counted_reg || pkt_start)) begin // [RULE_11] [RULE_15]
			count <= count + WIDTH'(regbank_pkg::SYMERR_ONE); // [RULE_13]
		end
	end

endmodule

`default_nettype wire

// ---- phy_vendor_mode_status_regs.sv ----
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RULE_01: Mode register bit 13 enables energy-detect power-down; resets to zero.
// RULE_02: Mode bit 9 loops received packets back to line, 100BASE-TX only.
// RULE_03: Remote loopback keeps working while the isolate control is asserted.
// RULE_04: Mode bit 6 selects primary (0, default) or alternate (1) interrupt scheme.
// RULE_05: Energy-present drops to zero after 256 ms without valid line energy.
// RULE_06: Hardware reset sets energy-present to one; soft reset leaves it.
// RULE_07: Software writes one to special-modes bit 14 and ignores it on read.
// RULE_08: Mode field bits 7:5 reset from the three mode straps, then writable.
// RULE_09: Address field bits 4:0 is management address and scrambler seed.
// RULE_10: Address field reset value comes from the single address strap.
// RULE_11: In 100BASE-TX, invalid symbols, idle included, advance the error counter.
// RULE_12: The error counter advances at most once per received packet.
// RULE_13: The error counter wraps to zero after its maximum value.
// RULE_14: Reset clears the error counter; reads leave it unchanged.
// RULE_15: The error counter holds still during 10BASE-T operation.
// RULE_16: Crossover bit 15 zero enables auto crossover; one uses bit 13 manually.
// RULE_17: Manual pairing: bit 13 zero straight, one swapped.
// RULE_18: Crossover register bit 4 reports 10BASE-T polarity, one when reversed.
// RULE_19: A latched-high status bit holds one until the register is read.
// RULE_20: Reserved read-only bits read zero and ignore writes.
module phy_vendor_mode_status_regs #(
	parameter longint ENERGY_TIMEOUT_CYCLES = regbank_pkg::ENERGY_TIMEOUT_CYC,
	parameter int     SYMERR_W              = 16
) (
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [regbank_pkg::ADDR_W-1:0]       paddr,
	input  wire logic [31:0]                          pwdata,
	input  wire logic [3:0]                           pstrb,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	input  wire logic [regbank_pkg::MODE_W-1:0]       mode_strap,
	input  wire logic                                 addr_strap,
	input  wire logic                                 isolate,
	input  wire logic                                 speed_100,
	input  wire regbank_pkg::line_events_t            line_ev,
	input  wire logic [7:0]                           rx_data_in,
	input  wire logic                                 rx_valid_in,
	output logic      [7:0]                           loop_tx_data,
	output logic                                      loop_tx_valid,
	output logic                                      pair_swap,
	output regbank_pkg::phy_ctrl_t                    ctrl,
	output logic      [regbank_pkg::ADDR_FLD_W-1:0]   scrambler_seed
);

	localparam int TMR_W = 32;
	localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(ENERGY_TIMEOUT_CYCLES - 1);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [7:0] idx;
	logic       acc;
	logic       wr;
	logic       rd;
	logic       hit;
	logic       lo_en;
	logic       hi_en;

	assign idx     = paddr[regbank_pkg::ADDR_W-1:2];
	assign acc     = psel && penable;
	assign wr      = acc && pwrite;
	assign rd      = acc && !pwrite;
	assign pready  = 1'b1;
	assign lo_en   = pstrb[0];
	assign hi_en   = pstrb[1];

	// Known indexes; anything else answers with an error
	always_comb begin
		case (idx)
			regbank_pkg::IDX_MODE_CTRL,
			regbank_pkg::IDX_SPECIAL,
			regbank_pkg::IDX_SYMERR,
			regbank_pkg::IDX_XOVER,
			regbank_pkg::IDX_SOFT_CTRL,
			regbank_pkg::IDX_LINE_STATUS: hit = 1'b1;
			default:                      hit = 1'b0;
		endcase
	end

	assign pslverr = acc && !hit;

	// ------------------------------------------------------------
	// Soft reset pulse
	// ------------------------------------------------------------
	// Self-clearing: a write of one resets only the soft-resettable fields
	logic soft_rst;
	assign soft_rst = wr && (idx == regbank_pkg::IDX_SOFT_CTRL) && lo_en
		&& pwdata[regbank_pkg::BIT_SOFT_RESET];

	// ------------------------------------------------------------
	// Mode control/status register fields
	// ------------------------------------------------------------
	logic edpd_reg;
	logic loop_reg;
	logic alt_irq_reg;
	logic mode_wr;

	assign mode_wr = wr && (idx == regbank_pkg::IDX_MODE_CTRL);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edpd_reg    <= 1'b0; // [RULE_01]
			loop_reg    <= 1'b0;
			alt_irq_reg <= 1'b0; // [RULE_04]
		end else if (soft_rst) begin
			edpd_reg    <= 1'b0;
			loop_reg    <= 1'b0;
			alt_irq_reg <= 1'b0;
		end else begin
			if (mode_wr && hi_en) begin
				edpd_reg <= pwdata[regbank_pkg::BIT_EDPD];        // [RULE_01]
				loop_reg <= pwdata[regbank_pkg::BIT_REMOTE_LOOP]; // [RULE_02]
			end
			if (mode_wr && lo_en) begin
				alt_irq_reg <= pwdata[regbank_pkg::BIT_ALT_IRQ];  // [RULE_04]
			end
		end
	end

	// ------------------------------------------------------------
	// Energy-present timer
	// ------------------------------------------------------------
	// Soft reset is deliberately not in this process
	logic [TMR_W-1:0] quiet_cnt_reg;
	logic             energy_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_cnt_reg <= '0;
			energy_reg    <= 1'b1; // [RULE_06]
		end else if (line_ev.energy_seen) begin
			quiet_cnt_reg <= '0;
			energy_reg    <= 1'b1;
		end else if (quiet_cnt_reg == TMR_LAST) begin
			energy_reg    <= 1'b0; // [RULE_05]
		end else begin
			quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Special modes: straps caught after reset release
	// ------------------------------------------------------------
	// Straps are sampled by the first clock after release, never by the
	// asynchronous reset branch itself
	logic [regbank_pkg::MODE_W-1:0]     mode_reg;
	logic [regbank_pkg::ADDR_FLD_W-1:0] addr_reg;
	logic                               rsvd14_reg;
	logic                               strap_done_reg;
	logic                               spec_wr;

	assign spec_wr = wr && (idx == regbank_pkg::IDX_SPECIAL);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_reg <= 1'b0;
			mode_reg       <= '0;
			addr_reg       <= '0;
			rsvd14_reg     <= 1'b1;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			mode_reg       <= mode_strap;                                   // [RULE_08]
			addr_reg       <= {{(regbank_pkg::ADDR_FLD_W-1){1'b0}}, addr_strap}; // [RULE_10]
		end else begin
			if (spec_wr && lo_en) begin
				mode_reg <= pwdata[regbank_pkg::MODE_LSB +: regbank_pkg::MODE_W]; // [RULE_08]
				addr_reg <= pwdata[regbank_pkg::ADDR_FLD_W-1:0];
			end
			if (spec_wr && hi_en) begin
				rsvd14_reg <= pwdata[regbank_pkg::BIT_SPEC_RSVD1]; // [RULE_07]
			end
		end
	end

	// ------------------------------------------------------------
	// Symbol error counter
	// ------------------------------------------------------------
	logic [SYMERR_W-1:0] symerr;

	symbol_err_counter #(
		.WIDTH       (SYMERR_W)
	) u_symerr (
		.pclk        (pclk),
		.presetn     (presetn),
		.speed_100   (speed_100),
		.sym_invalid (line_ev.sym_invalid),
		.pkt_start   (line_ev.pkt_start),
		.count       (symerr)
	);

	// ------------------------------------------------------------
	// Crossover and polarity
	// ------------------------------------------------------------
	logic xover_dis_reg;
	logic pair_sel_reg;
	logic pol_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xover_dis_reg <= 1'b0; // [RULE_16]
			pair_sel_reg  <= 1'b0;
		end else if (soft_rst) begin
			xover_dis_reg <= 1'b0;
			pair_sel_reg  <= 1'b0;
		end else if (wr && (idx == regbank_pkg::IDX_XOVER) && hi_en) begin
			xover_dis_reg <= pwdata[regbank_pkg::BIT_XOVER_DIS]; // [RULE_16]
			pair_sel_reg  <= pwdata[regbank_pkg::BIT_PAIR_SEL];  // [RULE_17]
		end
	end

	// Polarity is only meaningful at 10 Mb/s, so it freezes at 100 Mb/s
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pol_reg <= 1'b0;
		end else if (!speed_100) begin
			pol_reg <= line_ev.pol_reversed; // [RULE_18]
		end
	end

	// Manual selection only when auto crossover is off; auto mode keeps straight
	// pairing here, the analog resolver overrides it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_swap <= 1'b0;
		end else begin
			pair_swap <= xover_dis_reg && pair_sel_reg; // [RULE_16] [RULE_17]
		end
	end

	// ------------------------------------------------------------
	// Latched-high energy-loss status
	// ------------------------------------------------------------
	// Set wins over the clear-on-read in the same cycle
	logic energy_prev_reg;
	logic energy_lost_reg;
	logic status_rd;

	assign status_rd = rd && (idx == regbank_pkg::IDX_LINE_STATUS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			energy_prev_reg <= 1'b1;
			energy_lost_reg <= 1'b0;
		end else begin
			energy_prev_reg <= energy_reg;
			if (energy_prev_reg && !energy_reg) begin
				energy_lost_reg <= 1'b1; // [RULE_19]
			end else if (status_rd) begin
				energy_lost_reg <= 1'b0; // [RULE_19]
			end
		end
	end

	// ------------------------------------------------------------
	// Remote loopback path
	// ------------------------------------------------------------
	// Isolate is ignored on purpose: the loop lives on the line side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_tx_data  <= 8'h00;
			loop_tx_valid <= 1'b0;
		end else begin
			loop_tx_data  <= rx_data_in;
			loop_tx_valid <= rx_valid_in && loop_reg && speed_100; // [RULE_02] [RULE_03]
		end
	end

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	assign ctrl.energy_detect_powerdown_en = edpd_reg;
	assign ctrl.remote_loop_en             = loop_reg;
	assign ctrl.alternate_irq_select       = alt_irq_reg;
	assign ctrl.auto_crossover_disable     = xover_dis_reg;
	assign ctrl.manual_pair_select         = pair_sel_reg;
	assign ctrl.mode                       = mode_reg;
	assign ctrl.mgmt_address               = addr_reg;   // [RULE_09]
	assign scrambler_seed                  = addr_reg;   // [RULE_09]

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// Reserved read-only bits are built as zero, so they read zero and ignore writes
	logic [15:0] rd_word;

	always_comb begin
		rd_word = 16'h0000; // [RULE_20]
		case (idx)
			regbank_pkg::IDX_MODE_CTRL: begin
				rd_word[regbank_pkg::BIT_EDPD]        = edpd_reg;
				rd_word[regbank_pkg::BIT_REMOTE_LOOP] = loop_reg;
				rd_word[regbank_pkg::BIT_ALT_IRQ]     = alt_irq_reg;
				rd_word[regbank_pkg::BIT_ENERGY]      = energy_reg;
			end
			regbank_pkg::IDX_SPECIAL: begin
				rd_word[regbank_pkg::BIT_SPEC_RSVD1]                         = rsvd14_reg;
				rd_word[regbank_pkg::MODE_LSB +: regbank_pkg::MODE_W]        = mode_reg;
				rd_word[regbank_pkg::ADDR_FLD_W-1:0]                         = addr_reg;
			end
			regbank_pkg::IDX_SYMERR: begin
				rd_word = 16'(symerr); // [RULE_14]
			end
			regbank_pkg::IDX_XOVER: begin
				rd_word[regbank_pkg::BIT_XOVER_DIS] = xover_dis_reg;
				rd_word[regbank_pkg::BIT_PAIR_SEL]  = pair_sel_reg;
				rd_word[regbank_pkg::BIT_RX_POL]    = pol_reg; // [RULE_18]
			end
			regbank_pkg::IDX_LINE_STATUS: begin
				rd_word[regbank_pkg::BIT_SPEED_100] = speed_100;
				rd_word[regbank_pkg::BIT_ISOLATE]   = isolate;
				rd_word[regbank_pkg::BIT_ENERGY + 1] = energy_lost_reg;
			end
			default: begin
				rd_word = 16'h0000;
			end
		endcase
	end

	// Read data registered at the setup-phase edge, ready for the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {16'h0000, rd_word};
		end
	end

endmodule

`default_nettype wire

// ---- regbank_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none

module regbank_asserts #(
	parameter longint ENERGY_TIMEOUT_CYCLES = 20,
	parameter int     SYMERR_W              = 16
) (
	input wire logic                               pclk,
	input wire logic                               presetn,
	input wire logic                               psel,
	input wire logic                               penable,
	input wire logic                               pwrite,
	input wire logic [regbank_pkg::ADDR_W-1:0]     paddr,
	input wire logic [31:0]                        pwdata,
	input wire logic [3:0]                         pstrb,
	input wire logic [31:0]                        prdata,
	input wire logic                               pready,
	input wire logic                               pslverr,
	input wire logic [regbank_pkg::MODE_W-1:0]     mode_strap,
	input wire logic                               addr_strap,
	input wire logic                               isolate,
	input wire logic                               speed_100,
	input wire regbank_pkg::line_events_t          line_ev,
	input wire logic [7:0]                         rx_data_in,
	input wire logic                               rx_valid_in,
	input wire logic [7:0]                         loop_tx_data,
	input wire logic                               loop_tx_valid,
	input wire logic                               pair_swap,
	input wire regbank_pkg::phy_ctrl_t             ctrl,
	input wire logic [regbank_pkg::ADDR_FLD_W-1:0] scrambler_seed
);
	// ------------------------------------------------------------
	// Decode of the word being accessed
	// ------------------------------------------------------------
	wire logic [7:0] idx;
	wire logic       acc;
	wire logic       mapped;
	// Access phase as the slave sees it
	assign idx = paddr[9:2];
	assign acc = psel && penable && pready;
	assign mapped = idx inside {regbank_pkg::IDX_MODE_CTRL, regbank_pkg::IDX_SPECIAL, regbank_pkg::IDX_SYMERR,
		regbank_pkg::IDX_XOVER, regbank_pkg::IDX_SOFT_CTRL, regbank_pkg::IDX_LINE_STATUS};

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	unmapped_err_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h00000000))
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc && mapped |-> !pslverr && prdata[31:16] == 16'h0000)
		else $error("mapped access refused or upper half set");
	mode_rsvd_a: assert property (acc && !pwrite && idx == regbank_pkg::IDX_MODE_CTRL |-> (prdata & 32'h0000DDBD) == 0)
		else $error("reserved mode bits read nonzero");
	xover_rsvd_a: assert property (acc && !pwrite && idx == regbank_pkg::IDX_XOVER |-> (prdata & 32'h00005FEF) == 0)
		else $error("reserved crossover bits read nonzero");
	seed_copy_a: assert property (scrambler_seed == ctrl.mgmt_address)
		else $error("scrambler seed differs from address field");
	loop_echo_a: assert property (rx_valid_in && ctrl.remote_loop_en && speed_100
		|=> loop_tx_valid && loop_tx_data == $past(rx_data_in))
		else $error("received byte not looped back");
	loop_quiet_a: assert property (!speed_100 || !ctrl.remote_loop_en |=> !loop_tx_valid)
		else $error("loopback active outside 100 mode");
	pair_follow_a: assert property (##1 pair_swap == $past(ctrl.auto_crossover_disable && ctrl.manual_pair_select))
		else $error("pair swap does not follow manual select");
	strap_load_a: assert property ($rose(presetn) |=> ctrl.mode == $past(mode_strap)
		&& ctrl.mgmt_address == {4'h0, $past(addr_strap)})
		else $error("strap values not loaded after reset");
	edpd_write_a: assert property (acc && pwrite && pstrb[1] && idx == regbank_pkg::IDX_MODE_CTRL
		|=> ctrl.energy_detect_powerdown_en == $past(pwdata[13]))
		else $error("power-down enable not written");
	irq_write_a: assert property (acc && pwrite && pstrb[0] && idx == regbank_pkg::IDX_MODE_CTRL
		|=> ctrl.alternate_irq_select == $past(pwdata[6]))
		else $error("interrupt scheme select not written");
endmodule

bind phy_vendor_mode_status_regs regbank_asserts #(.ENERGY_TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES), .SYMERR_W(SYMERR_W))
	regbank_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mode_strap(mode_strap), .addr_strap(addr_strap), .isolate(isolate), .speed_100(speed_100),
	.line_ev(line_ev), .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .loop_tx_data(loop_tx_data),
	.loop_tx_valid(loop_tx_valid), .pair_swap(pair_swap), .ctrl(ctrl), .scrambler_seed(scrambler_seed));

`default_nettype wire

// ---- mgmt_master.sv ----
`timescale 1ns/1ns
`default_nettype none

module mgmt_master (
	input  wire logic                           pclk,
	input  wire logic                           pready,
	input  wire logic [31:0]                    prdata,
	input  wire logic                           pslverr,
	output logic                                psel,
	output logic                                penable,
	output logic                                pwrite,
	output logic      [regbank_pkg::ADDR_W-1:0] paddr,
	output logic      [31:0]                    pwdata,
	output logic      [3:0]                     pstrb
);
	// ------------------------------------------------------------
	// Bus idle state
	// ------------------------------------------------------------
	// Full words only; registers live in the low half
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
	end

	// One transfer; on release address and data are inverted so stale values never look valid
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask
endmodule

`default_nettype wire

// ---- tb_phy_vendor_mode_status_regs.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_phy_vendor_mode_status_regs;
	logic pclk, presetn, pwrite, psel, penable, pready, pslverr;
	logic isolate, speed_100, rx_valid_in, loop_tx_valid, pair_swap, addr_strap;
	logic [regbank_pkg::ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pstrb, base;
	logic [2:0] mode_strap;
	logic [7:0] rx_data_in, loop_tx_data;
	logic [4:0] scrambler_seed;
	logic e;
	regbank_pkg::line_events_t line_ev;
	regbank_pkg::phy_ctrl_t ctrl;
	int err_count, num_checks, cyc;
	logic [15:0] wv [4] = '{16'hFFFF, 16'h8000, 16'h2000, 16'hA000};

	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	// Short energy timeout keeps the loss test brief
	phy_vendor_mode_status_regs #(.ENERGY_TIMEOUT_CYCLES(20), .SYMERR_W(16)) phy_vendor_mode_status_regs_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mode_strap(mode_strap), .addr_strap(addr_strap), .isolate(isolate), .speed_100(speed_100),
		.line_ev(line_ev), .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .loop_tx_data(loop_tx_data),
		.loop_tx_valid(loop_tx_valid), .pair_swap(pair_swap), .ctrl(ctrl), .scrambler_seed(scrambler_seed));
	mgmt_master mgmt_master_inst (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [15:0] d);
		mgmt_master_inst.xfer(1'b1, i, d, r, e);
	endtask
	task automatic rchk(input logic [7:0] i, input logic [31:0] exp);
		mgmt_master_inst.xfer(1'b0, i, 16'h0000, r, e);
		chk(r, exp);
	endtask
	// Line events {energy, invalid symbol, packet start, polarity} for n cycles
	task automatic pulse(input logic [3:0] v, input int n);
		@(posedge pclk);
		line_ev <= regbank_pkg::line_events_t'(v);
		repeat (n) @(posedge pclk);
		line_ev <= regbank_pkg::line_events_t'(base);
	endtask
	task automatic loop(input logic s, input logic [7:0] d, input logic ok);
		@(posedge pclk);
		speed_100 <= s;
		rx_data_in <= d;
		rx_valid_in <= 1'b1;
		@(posedge pclk);
		rx_valid_in <= 1'b0;
		#1;
		chk({23'h0, loop_tx_valid, ok ? loop_tx_data : 8'h00}, {23'h0, ok, ok ? d : 8'h00});
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Wrap test needs some 65,536 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_count++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		base = 4'h8;
		line_ev = regbank_pkg::line_events_t'(4'h8);
		mode_strap = 3'h5;
		addr_strap = 1'b1;
		isolate = 1'b0;
		speed_100 = 1'b1;
		rx_data_in = 8'h00;
		rx_valid_in = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rchk(regbank_pkg::IDX_MODE_CTRL, 32'h00000002);
		rchk(regbank_pkg::IDX_SPECIAL, 32'h000040A1);
		rchk(regbank_pkg::IDX_SYMERR, 32'h00000000);
		rchk(regbank_pkg::IDX_XOVER, 32'h00000000);
		mgmt_master_inst.xfer(1'b0, 8'h13, 16'h0000, r, e);
		chk({e, r[30:0]}, 32'h80000000);
		wr(regbank_pkg::IDX_MODE_CTRL, 16'hFFFF);
		rchk(regbank_pkg::IDX_MODE_CTRL, 32'h00002242);
		chk({29'h0, ctrl.energy_detect_powerdown_en, ctrl.remote_loop_en, ctrl.alternate_irq_select}, 32'h7);
		wr(regbank_pkg::IDX_SPECIAL, 16'hFFFF);
		rchk(regbank_pkg::IDX_SPECIAL, 32'h000040FF);
		chk({24'h0, ctrl.mode, scrambler_seed}, 32'h000000FF);
		// Loopback must ignore isolate and stop outside 100 mode
		isolate <= 1'b1;
		loop(1'b1, 8'hA5, 1'b1);
		loop(1'b0, 8'h3C, 1'b0);
		wr(regbank_pkg::IDX_MODE_CTRL, 16'h0000);
		loop(1'b1, 8'h66, 1'b0);
		for (int k = 0; k < 4; k++) begin
			wr(regbank_pkg::IDX_XOVER, wv[k]);
			rchk(regbank_pkg::IDX_XOVER, {16'h0, wv[k] & 16'hA000});
			chk({31'h0, pair_swap}, {31'h0, (wv[k] & 16'hA000) == 16'hA000});
		end
		speed_100 <= 1'b0;
		base = 4'h9;
		pulse(4'h9, 2);
		rchk(regbank_pkg::IDX_XOVER, 32'h0000A010);
		base = 4'h8;
		pulse(4'h8, 2);
		rchk(regbank_pkg::IDX_XOVER, 32'h0000A000);
		// Several bad symbols in one packet count once
		speed_100 <= 1'b1;
		pulse(4'hA, 1);
		pulse(4'hC, 1);
		pulse(4'hC, 1);
		pulse(4'hC, 1);
		rchk(regbank_pkg::IDX_SYMERR, 32'h00000001);
		rchk(regbank_pkg::IDX_SYMERR, 32'h00000001);
		speed_100 <= 1'b0;
		pulse(4'hE, 3);
		rchk(regbank_pkg::IDX_SYMERR, 32'h00000001);
		speed_100 <= 1'b1;
		pulse(4'hE, 65534);
		rchk(regbank_pkg::IDX_SYMERR, 32'h0000FFFF);
		pulse(4'hE, 1);
		pulse(4'hC, 1);
		rchk(regbank_pkg::IDX_SYMERR, 32'h00000000);
		// Energy loss survives a soft reset, which clears the controls
		wr(regbank_pkg::IDX_MODE_CTRL, 16'h2240);
		base = 4'h0;
		pulse(4'h0, 1);
		rchk(regbank_pkg::IDX_MODE_CTRL, 32'h00002242);
		repeat (25) @(posedge pclk);
		rchk(regbank_pkg::IDX_MODE_CTRL, 32'h00002240);
		wr(regbank_pkg::IDX_SOFT_CTRL, 16'h0001);
		rchk(regbank_pkg::IDX_MODE_CTRL, 32'h00000000);
		rchk(regbank_pkg::IDX_SPECIAL, 32'h000040FF);
		base = 4'h8;
		pulse(4'h8, 2);
		rchk(regbank_pkg::IDX_MODE_CTRL, 32'h00000002);
		rchk(regbank_pkg::IDX_LINE_STATUS, 32'h00000007);
		rchk(regbank_pkg::IDX_LINE_STATUS, 32'h00000003);
		stop_test();
	end
endmodule

`default_nettype wire
